/* File: tcr_pkg.sv */
// Constants, carriers and register map of the timing card auxiliary register bank
//----------------------------------------------------------------------
// Notes on behaviour
//----------------------------------------------------------------------
// Notes on behaviour
// [R1] Soft interrupt bits readable at two offsets
// [R2] Set/clear aliases touch only selected interrupt bits
// [R3] Register drives output enable of I/O lines
// [R4] Drive set/clear aliases touch only selected bits
// [R5] Register switches termination of I/O lines
// [R6] Termination set/clear aliases touch only selected bits
// [R7] Receive ring pointers share one register, head readable
// [R8] Transmit ring pointers share one register, tail readable
// [R9] Any debug bit set halts GPS link
// [R10] Any write to error register resets link
// [R11] Error register: PPS, parity, short start, framing bytes
// [R12] Receive buffer mapped over its address window
// [R13] Transmit buffer mapped over its address window
// [R14] Disabled IRIG input is ignored entirely
// [R15] Enable toggle returns IRIG input to reset
// [R16] IRIG control register configures input source
// [R17] IRIG error counts zeroed when input enabled
// [R18] Zero bits in set/clear writes change nothing
package tcr_pkg;

    //------------------------------------------------------------------
    // Widths
    //------------------------------------------------------------------
    localparam int ADDR_W   = 18;
    localparam int DATA_W   = 32;
    localparam int LINES_W  = 12;
    localparam int PTR_W    = 9;
    localparam int RING_D   = 512;
    localparam int DBG_W    = 8;

    //------------------------------------------------------------------
    // Register byte offsets
    //------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_SOFT_INT       = 18'h03000;
    localparam logic [ADDR_W-1:0] OFS_SOFT_INT_SET   = 18'h03010;
    localparam logic [ADDR_W-1:0] OFS_SOFT_INT_CLR   = 18'h03020;
    localparam logic [ADDR_W-1:0] OFS_SOFT_INT_A     = 18'h30000;
    localparam logic [ADDR_W-1:0] OFS_SOFT_INT_SET_A = 18'h30010;
    localparam logic [ADDR_W-1:0] OFS_SOFT_INT_CLR_A = 18'h30020;
    localparam logic [ADDR_W-1:0] OFS_DRIVE          = 18'h03040;
    localparam logic [ADDR_W-1:0] OFS_DRIVE_SET      = 18'h03044;
    localparam logic [ADDR_W-1:0] OFS_DRIVE_CLR      = 18'h03048;
    localparam logic [ADDR_W-1:0] OFS_TERM           = 18'h03050;
    localparam logic [ADDR_W-1:0] OFS_TERM_SET       = 18'h03054;
    localparam logic [ADDR_W-1:0] OFS_TERM_CLR       = 18'h03058;
    localparam logic [ADDR_W-1:0] OFS_RX_PTRS        = 18'h03200;
    localparam logic [ADDR_W-1:0] OFS_TX_PTRS        = 18'h03204;
    localparam logic [ADDR_W-1:0] OFS_GNSS_DEBUG     = 18'h03208;
    localparam logic [ADDR_W-1:0] OFS_GNSS_ERR       = 18'h0320c;
    localparam logic [ADDR_W-1:0] OFS_RX_BUF_LO      = 18'h04000;
    localparam logic [ADDR_W-1:0] OFS_RX_BUF_HI      = 18'h047ff;
    localparam logic [ADDR_W-1:0] OFS_TX_BUF_LO      = 18'h04800;
    localparam logic [ADDR_W-1:0] OFS_TX_BUF_HI      = 18'h04fff;
    localparam logic [ADDR_W-1:0] OFS_IRIG_EN        = 18'h06000;
    localparam logic [ADDR_W-1:0] OFS_IRIG_CTRL      = 18'h06004;
    localparam logic [ADDR_W-1:0] OFS_IRIG_ERR       = 18'h0600c;

    //------------------------------------------------------------------
    // Field positions and reset values
    //------------------------------------------------------------------
    localparam int HEAD_LSB = 16;
    localparam int TAIL_LSB = 0;
    localparam int IRIG_EN_BIT = 0;
    localparam logic [DATA_W-1:0] IRIG_CTRL_RST = 32'h0000_0000;
    localparam logic [LINES_W-1:0] LINES_RST    = 12'h000;

    //------------------------------------------------------------------
    // Carriers
    //------------------------------------------------------------------
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } tcr_bus_req_t;

    // Link error events, one-cycle pulses; order matches the count bytes
    typedef struct packed {
        logic pps_ok;
        logic parity;
        logic short_start;
        logic framing;
    } tcr_gnss_evt_t;

    typedef struct packed {
        logic pps_ok;
        logic am_frame;
        logic dcls_frame;
        logic sync;
    } tcr_irig_evt_t;

endpackage

/* File: tcr_regbank.sv */
// Timing card auxiliary register bank: interrupts, I/O lines, GPS rings, IRIG input
module tcr_regbank
    import tcr_pkg::*;
(
    // Clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  rst,
    // Register port
    input  wire tcr_bus_req_t          bus_req,
    output logic [DATA_W-1:0]          bus_rdata,
    // I/O line control
    output logic [LINES_W-1:0]         soft_int_bits,
    output logic [LINES_W-1:0]         line_drive_en,
    output logic [LINES_W-1:0]         line_term_on,
    // GPS receive stream
    input  wire logic                  gnss_rx_valid,
    input  wire logic [DATA_W-1:0]     gnss_rx_data,
    output logic                       gnss_rx_ready,
    // GPS transmit stream
    output logic                       gnss_tx_valid,
    output logic [DATA_W-1:0]          gnss_tx_data,
    input  wire logic                  gnss_tx_ready,
    // GPS link status
    input  wire tcr_gnss_evt_t         gnss_evt,
    output logic                       gnss_link_active,
    output logic                       gnss_link_reset,
    // IRIG input
    input  wire logic                  irig_pin,
    input  wire tcr_irig_evt_t         irig_evt,
    output logic                       irig_enabled,
    output logic                       irig_sig,
    output logic                       irig_reset,
    output logic [DATA_W-1:0]          irig_ctrl
);

    //------------------------------------------------------------------
    // State
    //------------------------------------------------------------------
    typedef struct packed {
        logic [LINES_W-1:0]   soft_int;
        logic [LINES_W-1:0]   drive;
        logic [LINES_W-1:0]   term;
        logic [PTR_W-1:0]     rx_head;
        logic [PTR_W-1:0]     rx_tail;
        logic [PTR_W-1:0]     tx_head;
        logic [PTR_W-1:0]     tx_tail;
        logic [DBG_W-1:0]     debug;
        logic [3:0][7:0]      gerr;
        logic                 link_rst;
        logic                 tx_valid;
        logic [DATA_W-1:0]    tx_data;
        logic                 irig_en;
        logic                 irig_rst;
        logic [DATA_W-1:0]    irig_ctrl;
        logic [3:0][7:0]      ierr;
        logic                 irig_s1;
        logic                 irig_s2;
        logic                 irig_out;
        logic [DATA_W-1:0]    rdata;
        logic [1:0]           rsel;
    } tcr_state_t;

    tcr_state_t st_r;
    tcr_state_t st_nxt;

    // Ring memories sit outside the state record: too large to copy every cycle
    logic [DATA_W-1:0] rx_mem [RING_D];
    logic [DATA_W-1:0] tx_mem [RING_D];
    logic [DATA_W-1:0] rx_rd_q;
    logic [DATA_W-1:0] tx_rd_q;
    logic [DATA_W-1:0] tx_pop_q;

    //------------------------------------------------------------------
    // Decode
    //------------------------------------------------------------------
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] a;
    logic [DATA_W-1:0] wd;
    logic              in_rx_buf;
    logic              in_tx_buf;
    logic [PTR_W-1:0]  buf_idx;
    logic              link_on;
    logic              rx_push;
    logic              tx_pop;
    logic              err_wr;
    logic              en_wr;
    logic              en_toggle;
    logic              en_rise;

    assign wr        = bus_req.wr;
    assign rd        = bus_req.rd;
    assign a         = bus_req.addr;
    assign wd        = bus_req.wdata;
    assign in_rx_buf = (a >= OFS_RX_BUF_LO) && (a <= OFS_RX_BUF_HI);            // [R12]
    assign in_tx_buf = (a >= OFS_TX_BUF_LO) && (a <= OFS_TX_BUF_HI);            // [R13]
    assign buf_idx   = a[PTR_W+1:2];
    assign err_wr    = wr && (a == OFS_GNSS_ERR);
    // Link runs only with no debug bit set, not in an error register write cycle and not in its reset cycle
    assign link_on   = (st_r.debug == '0) && !st_r.link_rst && !err_wr;         // [R9]
    assign rx_push   = link_on && gnss_rx_valid && gnss_rx_ready;
    assign tx_pop    = link_on && (st_r.tx_head != st_r.tx_tail)
                       && (!st_r.tx_valid || (gnss_tx_valid && gnss_tx_ready));
    assign en_wr     = wr && (a == OFS_IRIG_EN);
    assign en_toggle = en_wr && (wd[IRIG_EN_BIT] != st_r.irig_en);
    assign en_rise   = en_toggle && wd[IRIG_EN_BIT];

    //------------------------------------------------------------------
    // Memories
    //------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rx_push) begin
            rx_mem[st_r.rx_head] <= gnss_rx_data;
        end
        if (wr && in_tx_buf) begin
            tx_mem[buf_idx] <= wd;                                               // [R13]
        end
        rx_rd_q  <= rx_mem[buf_idx];                                             // [R12]
        tx_rd_q  <= tx_mem[buf_idx];
        tx_pop_q <= tx_mem[st_r.tx_tail];
    end

    //------------------------------------------------------------------
    // Next state
    //------------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        st_nxt.link_rst = 1'b0;
        st_nxt.irig_rst = 1'b0;

        // Soft interrupt bits and their aliases
        if (wr && (a == OFS_SOFT_INT || a == OFS_SOFT_INT_A)) begin
            st_nxt.soft_int = wd[LINES_W-1:0];                                   // [R1]
        end
        if (wr && (a == OFS_SOFT_INT_SET || a == OFS_SOFT_INT_SET_A)) begin
            st_nxt.soft_int = st_r.soft_int | wd[LINES_W-1:0];                   // [R2] [R18]
        end
        if (wr && (a == OFS_SOFT_INT_CLR || a == OFS_SOFT_INT_CLR_A)) begin
            st_nxt.soft_int = st_r.soft_int & ~wd[LINES_W-1:0];                  // [R2] [R18]
        end

        // Line drive enable
        if (wr && a == OFS_DRIVE) begin
            st_nxt.drive = wd[LINES_W-1:0];                                      // [R3]
        end
        if (wr && a == OFS_DRIVE_SET) begin
            st_nxt.drive = st_r.drive | wd[LINES_W-1:0];                         // [R4] [R18]
        end
        if (wr && a == OFS_DRIVE_CLR) begin
            st_nxt.drive = st_r.drive & ~wd[LINES_W-1:0];                        // [R4] [R18]
        end

        // Line termination
        if (wr && a == OFS_TERM) begin
            st_nxt.term = wd[LINES_W-1:0];                                       // [R5]
        end
        if (wr && a == OFS_TERM_SET) begin
            st_nxt.term = st_r.term | wd[LINES_W-1:0];                           // [R6] [R18]
        end
        if (wr && a == OFS_TERM_CLR) begin
            st_nxt.term = st_r.term & ~wd[LINES_W-1:0];                          // [R6] [R18]
        end

        // Ring pointers: software owns rx tail and tx head
        if (wr && a == OFS_RX_PTRS) begin
            st_nxt.rx_tail = wd[TAIL_LSB +: PTR_W];                              // [R7]
        end
        if (wr && a == OFS_TX_PTRS) begin
            st_nxt.tx_head = wd[HEAD_LSB +: PTR_W];                              // [R8]
        end
        if (rx_push) begin
            st_nxt.rx_head = st_r.rx_head + 1'b1;                                // [R7]
        end

        // Transmit output stage
        if (gnss_tx_valid && gnss_tx_ready) begin
            st_nxt.tx_valid = 1'b0;
        end
        if (tx_pop) begin
            st_nxt.tx_tail  = st_r.tx_tail + 1'b1;                               // [R8]
            st_nxt.tx_valid = 1'b1;
        end
        if (st_r.tx_valid && !gnss_tx_ready && !link_on) begin
            st_nxt.tx_valid = 1'b0;                                              // [R9]
        end

        // Debug bits
        if (wr && a == OFS_GNSS_DEBUG) begin
            st_nxt.debug = wd[DBG_W-1:0];
        end

        // Error counts; a write restarts link and counts
        for (int i = 0; i < 4; i++) begin
            if (err_wr) begin
                st_nxt.gerr[i] = 8'h00;                                          // [R10]
            end
            if (link_on && gnss_evt[i]) begin
                st_nxt.gerr[i] = err_wr ? 8'h01 : st_r.gerr[i] + 8'h01;          // [R11]
            end
        end
        if (err_wr) begin
            st_nxt.link_rst = 1'b1;                                              // [R10]
            st_nxt.tx_valid = 1'b0;
        end

        // IRIG input enable and control
        if (en_wr) begin
            st_nxt.irig_en = wd[IRIG_EN_BIT];
        end
        if (wr && a == OFS_IRIG_CTRL) begin
            st_nxt.irig_ctrl = wd;                                               // [R16]
        end
        if (en_toggle) begin
            st_nxt.irig_ctrl = IRIG_CTRL_RST;                                    // [R15]
            st_nxt.irig_rst  = 1'b1;                                             // [R15]
        end
        for (int i = 0; i < 4; i++) begin
            if (st_r.irig_en && irig_evt[i]) begin
                st_nxt.ierr[i] = st_r.ierr[i] + 8'h01;                           // [R14]
            end
            if (en_rise) begin
                st_nxt.ierr[i] = 8'h00;                                          // [R17]
            end
        end

        // IRIG pin: two-stage synchroniser, then gate on enable
        st_nxt.irig_s1  = irig_pin;
        st_nxt.irig_s2  = st_r.irig_s1;
        st_nxt.irig_out = st_r.irig_s2 && st_r.irig_en;                          // [R14]

        // Read data
        st_nxt.rsel  = 2'd0;
        st_nxt.rdata = '0;
        if (rd) begin
            if (in_rx_buf) begin
                st_nxt.rsel = 2'd1;
            end else if (in_tx_buf) begin
                st_nxt.rsel = 2'd2;
            end else begin
                case (a)
                    OFS_SOFT_INT,
                    OFS_SOFT_INT_A:  st_nxt.rdata[LINES_W-1:0] = st_r.soft_int;  // [R1]
                    OFS_DRIVE:       st_nxt.rdata[LINES_W-1:0] = st_r.drive;
                    OFS_TERM:        st_nxt.rdata[LINES_W-1:0] = st_r.term;
                    OFS_RX_PTRS: begin
                        st_nxt.rdata[HEAD_LSB +: PTR_W] = st_r.rx_head;          // [R7]
                        st_nxt.rdata[TAIL_LSB +: PTR_W] = st_r.rx_tail;
                    end
                    OFS_TX_PTRS: begin
                        st_nxt.rdata[HEAD_LSB +: PTR_W] = st_r.tx_head;
                        st_nxt.rdata[TAIL_LSB +: PTR_W] = st_r.tx_tail;          // [R8]
                    end
                    OFS_GNSS_DEBUG:  st_nxt.rdata[DBG_W-1:0] = st_r.debug;
                    OFS_GNSS_ERR:    st_nxt.rdata = st_r.gerr;                   // [R11]
                    OFS_IRIG_EN:     st_nxt.rdata[IRIG_EN_BIT] = st_r.irig_en;
                    OFS_IRIG_CTRL:   st_nxt.rdata = st_r.irig_ctrl;
                    OFS_IRIG_ERR:    st_nxt.rdata = st_r.ierr;
                    default:         st_nxt.rdata = '0;
                endcase
            end
        end
    end

    //------------------------------------------------------------------
    // Registers
    //------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st_r           <= '0;
            st_r.soft_int  <= LINES_RST;
            st_r.drive     <= LINES_RST;
            st_r.term      <= LINES_RST;
            st_r.irig_ctrl <= IRIG_CTRL_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    //------------------------------------------------------------------
    // Outputs
    //------------------------------------------------------------------
    // Word loads one cycle after the pop and is hidden till then
    logic tx_fresh_r;
    logic [DATA_W-1:0] tx_hold_r;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            tx_fresh_r <= 1'b0;
            tx_hold_r  <= '0;
        end else begin
            tx_fresh_r <= tx_pop;
            if (tx_fresh_r) begin
                tx_hold_r <= tx_pop_q;
            end
        end
    end

    always_comb begin
        case (st_r.rsel)
            2'd1:    bus_rdata = rx_rd_q;
            2'd2:    bus_rdata = tx_rd_q;
            default: bus_rdata = st_r.rdata;
        endcase
    end

    assign soft_int_bits    = st_r.soft_int;
    assign line_drive_en    = st_r.drive;
    assign line_term_on     = st_r.term;
    // Full ring refuses a word rather than overwrite unread data
    assign gnss_rx_ready    = link_on && ((st_r.rx_head + 1'b1) != st_r.rx_tail);
    assign gnss_tx_valid    = st_r.tx_valid && !tx_fresh_r;
    assign gnss_tx_data     = tx_hold_r;
    assign gnss_link_active = link_on;
    assign gnss_link_reset  = st_r.link_rst;
    assign irig_enabled     = st_r.irig_en;
    assign irig_sig         = st_r.irig_out;
    assign irig_reset       = st_r.irig_rst;
    assign irig_ctrl        = st_r.irig_ctrl;

endmodule

/* File: tcr_regbank_monitor.sv */
// Checker on the register bank ports
module tcr_regbank_monitor
    import tcr_pkg::*;
(
    // Clock and reset
    input wire logic                 ref_clk,
    input wire logic                 rst,
    // Register port
    input wire tcr_bus_req_t         bus_req,
    // Line registers
    input wire logic [LINES_W-1:0]   soft_int_bits,
    input wire logic [LINES_W-1:0]   line_drive_en,
    input wire logic [LINES_W-1:0]   line_term_on,
    // Link and IRIG status
    input wire logic                 gnss_rx_ready,
    input wire logic                 gnss_tx_valid,
    input wire logic                 gnss_tx_ready,
    input wire logic                 gnss_link_active,
    input wire logic                 gnss_link_reset,
    input wire logic                 irig_enabled,
    input wire logic                 irig_sig,
    input wire logic                 irig_reset,
    input wire logic [DATA_W-1:0]    irig_ctrl
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    wire [LINES_W-1:0] wd = bus_req.wdata[LINES_W-1:0];
    wire               wr = bus_req.wr;
    wire [ADDR_W-1:0]  ad = bus_req.addr;

    a_int_set_only: assert property (wr && (ad == OFS_SOFT_INT_SET || ad == OFS_SOFT_INT_SET_A)
        |=> soft_int_bits == ($past(soft_int_bits) | $past(wd))) else $error("int set wrong");
    a_int_clr_only: assert property (wr && (ad == OFS_SOFT_INT_CLR || ad == OFS_SOFT_INT_CLR_A)
        |=> soft_int_bits == ($past(soft_int_bits) & ~$past(wd))) else $error("int clear wrong");
    a_drive_write: assert property (wr && ad == OFS_DRIVE |=> line_drive_en == $past(wd))
        else $error("drive write lost");
    a_drive_set_only: assert property (wr && ad == OFS_DRIVE_SET
        |=> line_drive_en == ($past(line_drive_en) | $past(wd))) else $error("drive set wrong");
    a_term_clr_only: assert property (wr && ad == OFS_TERM_CLR
        |=> line_term_on == ($past(line_term_on) & ~$past(wd))) else $error("term clear wrong");
    a_link_reset_pulse: assert property (wr && ad == OFS_GNSS_ERR |-> !gnss_link_active
        ##1 (gnss_link_reset && !gnss_link_active) ##1 !gnss_link_reset) else $error("link reset pulse wrong");
    a_rx_needs_link: assert property (gnss_rx_ready |-> gnss_link_active)
        else $error("rx ready while halted");
    a_irig_ignored: assert property (!irig_enabled [*3] |-> !irig_sig)
        else $error("IRIG passed while off");
    a_irig_toggle_reset: assert property (wr && ad == OFS_IRIG_EN && bus_req.wdata[IRIG_EN_BIT] != irig_enabled
        |=> irig_reset && irig_ctrl == '0) else $error("IRIG toggle did not reset");
    a_irig_reset_cause: assert property (irig_reset |-> $past(wr) && $past(ad) == OFS_IRIG_EN)
        else $error("IRIG reset uncaused");

    c_err_write: cover property (wr && ad == OFS_GNSS_ERR);
    c_irig_toggle: cover property (irig_reset);
    c_tx_word: cover property (gnss_tx_valid && gnss_tx_ready);
endmodule

bind tcr_regbank tcr_regbank_monitor mon (.ref_clk(ref_clk), .rst(rst), .bus_req(bus_req),
    .soft_int_bits(soft_int_bits), .line_drive_en(line_drive_en), .line_term_on(line_term_on),
    .gnss_rx_ready(gnss_rx_ready), .gnss_tx_valid(gnss_tx_valid), .gnss_tx_ready(gnss_tx_ready),
    .gnss_link_active(gnss_link_active), .gnss_link_reset(gnss_link_reset), .irig_enabled(irig_enabled),
    .irig_sig(irig_sig), .irig_reset(irig_reset), .irig_ctrl(irig_ctrl));

/* File: tcr_gnss_model.sv */
// GNSS receiver model feeding and draining the rings
module tcr_gnss_model
    import tcr_pkg::*;
(
    // Clock
    input wire logic               ref_clk,
    // Words towards the bank
    output logic                   rx_valid,
    output logic [DATA_W-1:0]      rx_data,
    input wire logic               rx_ready,
    // Words from the bank
    input wire logic               tx_valid,
    input wire logic [DATA_W-1:0]  tx_data,
    output logic                   tx_ready
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [DATA_W-1:0] got_q [$];
    logic [1:0]        phase = 2'h0;
    logic              rdy_s = 1'b0;
    initial {rx_valid, rx_data, tx_ready} = '0;
    always @(negedge ref_clk) rdy_s = rx_ready;
    // Word held until taken, then inverted
    task automatic send(input logic [DATA_W-1:0] w);
        @(posedge ref_clk);
        rx_valid <= 1'b1;
        rx_data <= w;
        do @(posedge ref_clk); while (rdy_s !== 1'b1);
        rx_valid <= 1'b0;
        rx_data <= ~w;
    endtask
    // Ready one cycle in three: a slow sink
    always @(posedge ref_clk) begin
        phase <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
        tx_ready <= (phase == 2'h1);
        if (tx_valid && tx_ready)
            got_q.push_back(tx_data);
    end
endmodule

/* File: tcr_tb.sv */
// Self-checking testbench of the register bank
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin err_count++; \
    $display("mismatch %s expected %h seen %h", nm, ex, got); end end
module tb
    import tcr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    tcr_bus_req_t bus_req = '0;
    tcr_gnss_evt_t gnss_evt = '0;
    tcr_irig_evt_t irig_evt = '0;
    logic irig_pin = 1'b1;
    logic gnss_rx_valid, gnss_rx_ready, gnss_tx_valid, gnss_tx_ready;
    logic gnss_link_active, gnss_link_reset, irig_enabled, irig_sig, irig_reset;
    logic [DATA_W-1:0] bus_rdata, gnss_rx_data, gnss_tx_data, irig_ctrl;
    logic [LINES_W-1:0] soft_int_bits, line_drive_en, line_term_on;
    int err_count = 0;
    int n_checks = 0;
    always #25 ref_clk = ~ref_clk;

    tcr_regbank dut (.ref_clk(ref_clk), .rst(rst), .bus_req(bus_req), .bus_rdata(bus_rdata),
        .soft_int_bits(soft_int_bits), .line_drive_en(line_drive_en), .line_term_on(line_term_on),
        .gnss_rx_valid(gnss_rx_valid), .gnss_rx_data(gnss_rx_data), .gnss_rx_ready(gnss_rx_ready),
        .gnss_tx_valid(gnss_tx_valid), .gnss_tx_data(gnss_tx_data), .gnss_tx_ready(gnss_tx_ready),
        .gnss_evt(gnss_evt), .gnss_link_active(gnss_link_active), .gnss_link_reset(gnss_link_reset),
        .irig_pin(irig_pin), .irig_evt(irig_evt), .irig_enabled(irig_enabled), .irig_sig(irig_sig),
        .irig_reset(irig_reset), .irig_ctrl(irig_ctrl));
    tcr_gnss_model m (.ref_clk(ref_clk), .rx_valid(gnss_rx_valid), .rx_data(gnss_rx_data),
        .rx_ready(gnss_rx_ready), .tx_valid(gnss_tx_valid), .tx_data(gnss_tx_data), .tx_ready(gnss_tx_ready));

    task automatic stop_test();
        if (err_count == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic bus_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge ref_clk);
        bus_req <= '{a, d, 1'b1, 1'b0};
        @(posedge ref_clk);
        bus_req.wr <= 1'b0;
    endtask
    task automatic rd_chk(input string nm, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] ex);
        @(posedge ref_clk);
        bus_req <= '{a, '0, 1'b0, 1'b1};
        @(posedge ref_clk);
        bus_req.rd <= 1'b0;
        #1 `CHK(nm, ex, bus_rdata)
    endtask
    task automatic pulse(input logic [3:0] g, r, input int n);
        repeat (n) begin
            @(posedge ref_clk);
            gnss_evt <= g;
            irig_evt <= r;
            @(posedge ref_clk);
            gnss_evt <= '0;
            irig_evt <= '0;
        end
    endtask
    // Write, set, clear each line register, alias pair crossed
    task automatic t_lines();
        logic [ADDR_W-1:0] b, rb, st;
        logic [LINES_W-1:0] pv;
        for (int i = 0; i < 4; i++) begin
            b = (i == 0) ? OFS_SOFT_INT : (i == 1) ? OFS_SOFT_INT_A : (i == 2) ? OFS_DRIVE : OFS_TERM;
            rb = (i == 0) ? OFS_SOFT_INT_A : (i == 1) ? OFS_SOFT_INT : b;
            st = (i < 2) ? 18'h00010 : 18'h00004;
            rd_chk("line reset", rb, 32'h0);
            bus_wr(b, 32'hffff_f0a5);
            rd_chk("line write", rb, 32'h0000_00a5);
            bus_wr(b + st, 32'h0000_0300);
            rd_chk("line set", rb, 32'h0000_03a5);
            bus_wr(b + 2 * st, 32'h0000_0021);
            rd_chk("line clear", rb, 32'h0000_0384);
            rd_chk("alias reads zero", b + st, 32'h0);
            pv = (i < 2) ? soft_int_bits : (i == 2) ? line_drive_en : line_term_on;
            `CHK("line port", 12'h384, pv)
            bus_wr(b + 2 * st, 32'h0000_0fff);
        end
    endtask
    task automatic t_gnss_link();
        pulse(4'b1000, 4'h0, 3);
        pulse(4'b0100, 4'h0, 2);
        pulse(4'b0010, 4'h0, 1);
        pulse(4'b0001, 4'h0, 4);
        rd_chk("error counts", OFS_GNSS_ERR, 32'h0302_0104);
        bus_wr(OFS_GNSS_ERR, 32'h1234_5678);
        #1 `CHK("link reset", 1'b1, gnss_link_reset)
        rd_chk("counts after reset", OFS_GNSS_ERR, 32'h0);
        bus_wr(OFS_GNSS_DEBUG, 32'h0000_0080);
        #1 `CHK("link halted", 1'b0, gnss_link_active)
        `CHK("rx refused", 1'b0, gnss_rx_ready)
        pulse(4'b1000, 4'h0, 2);
        rd_chk("no count while halted", OFS_GNSS_ERR, 32'h0);
        bus_wr(OFS_GNSS_DEBUG, 32'h0000_0000);
        #1 `CHK("link resumed", 1'b1, gnss_link_active)
    endtask
    task automatic t_rings();
        for (int i = 0; i < 3; i++)
            m.send(32'hc0de_0000 + i);
        rd_chk("rx head", OFS_RX_PTRS, 32'h0003_0000);
        bus_wr(OFS_RX_BUF_LO + 4, 32'hdead_beef);
        for (int i = 0; i < 3; i++)
            rd_chk("rx buffer", OFS_RX_BUF_LO + 4 * i, 32'hc0de_0000 + i);
        bus_wr(OFS_TX_BUF_LO, 32'h5a5a_0001);
        bus_wr(OFS_TX_BUF_LO + 4, 32'ha5a5_0002);
        rd_chk("tx buffer", OFS_TX_BUF_LO + 4, 32'ha5a5_0002);
        bus_wr(OFS_TX_PTRS, 32'h0002_01ff);
        for (int k = 0; k < 200 && m.got_q.size() < 2; k++)
            @(posedge ref_clk);
        `CHK("tx count", 2, m.got_q.size())
        `CHK("tx word 0", 32'h5a5a_0001, m.got_q[0])
        `CHK("tx word 1", 32'ha5a5_0002, m.got_q[1])
        rd_chk("tx tail", OFS_TX_PTRS, 32'h0002_0002);
    endtask
    task automatic t_irig();
        `CHK("irig off", 1'b0, irig_sig)
        bus_wr(OFS_IRIG_CTRL, 32'h0000_5a3c);
        rd_chk("irig control", OFS_IRIG_CTRL, 32'h0000_5a3c);
        bus_wr(OFS_IRIG_EN, 32'h0000_0001);
        #1 `CHK("irig reset", 1'b1, irig_reset)
        `CHK("irig enabled", 1'b1, irig_enabled)
        `CHK("irig control cleared", 32'h0, irig_ctrl)
        repeat (4) @(posedge ref_clk);
        #1 `CHK("irig passes", 1'b1, irig_sig)
        pulse(4'h0, 4'b0001, 2);
        bus_wr(OFS_IRIG_EN, 32'h0000_0000);
        pulse(4'h0, 4'b0001, 1);
        irig_pin <= 1'b0;
        repeat (4) @(posedge ref_clk);
        irig_pin <= 1'b1;
        repeat (4) @(posedge ref_clk);
        #1 `CHK("irig ignored", 1'b0, irig_sig)
        rd_chk("irig counts", OFS_IRIG_ERR, 32'h0000_0002);
        bus_wr(OFS_IRIG_EN, 32'h0000_0001);
        rd_chk("irig counts zeroed", OFS_IRIG_ERR, 32'h0);
    endtask

    initial begin
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        t_lines();
        t_gnss_link();
        t_rings();
        t_irig();
        stop_test();
    end
    // Run needs under 1000 cycles
    initial begin
        repeat (5000) @(posedge ref_clk);
        err_count++;
        stop_test();
    end
endmodule
